// ### rsp_spi.sv
/*
 * serial slave access port: mode 0 shifter with auto-increment pointer
 * in front of the 32-byte map.
 * assumes sclk, ce_n and serial_in come from pins of another domain and
 * sclk is slow against clk (at least four clk periods per half cycle).
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsp_regs.svh"
module rsp_spi (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// serial pins
	input wire logic sclk,
	input wire logic ce_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// timekeeping side
	input wire logic tk_we,
	input wire logic [2:0] tk_addr,
	input wire logic [7:0] tk_data,
	output logic clock_hold
);
	import rsp_pkg::*;

	rsp_mem_if mif ();

	rsp_mem u_mem (
		.clk(clk),
		.bus(mif.map),
		.tk_we(tk_we),
		.tk_addr(tk_addr),
		.tk_data(tk_data)
	);

	// two-stage synchronisers; the second stage is read, and sck_d and ce_d add a delayed copy for edges
	logic sck_m, sck_s, sck_d;
	logic ce_m, ce_s, ce_d;
	logic sin_m, sin_s;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_m <= 1'b0;
			sck_s <= 1'b0;
			sck_d <= 1'b0;
			// all low: a chip enable already low at release shows no fall
			ce_m <= 1'b0;
			ce_s <= 1'b0;
			ce_d <= 1'b0;
			sin_m <= 1'b0;
			sin_s <= 1'b0;
		end else begin
			sck_m <= sclk;
			sck_s <= sck_m;
			sck_d <= sck_s;
			ce_m <= ce_n;
			ce_s <= ce_m;
			ce_d <= ce_s;
			sin_m <= serial_in;
			sin_s <= sin_m;
		end
	end

	// state of a transfer
	logic active;
	rsp_state_t state;
	logic [2:0] cnt;
	logic [7:0] sh;
	logic [7:0] tx;
	rsp_ptr_t ptr;

	// edges; only rises shift in and only falls shift out [RULE3]
	wire ce_fall = ce_d && !ce_s;
	wire sck_rise = sck_s && !sck_d;
	wire sck_fall = !sck_s && sck_d;
	// deselected: clock and data are not looked at [RULE8]
	wire live = active && !ce_s;
	wire rise = live && sck_rise;
	wire fall = live && sck_fall;
	wire byte_end = rise && (cnt == `RSP_LAST_BIT);
	wire [7:0] next_sh = {sh[6:0], sin_s};
	wire cmd_end = byte_end && (state == RSP_CMD);
	wire data_end = byte_end && (state != RSP_CMD);
	wire rd_load = fall && (state == RSP_RD) && (cnt == 3'h0);
	wire next_hold = live && (state != RSP_CMD) && rsp_is_clock(ptr);
	wire [7:0] rd_byte = rd_load ? mif.rdata : tx;

	// a byte is stored only when its eighth bit arrives [RULE15]
	assign mif.we = data_end && (state == RSP_WR);
	// bit 6 of the address never reaches the decode [RULE13]
	assign mif.waddr = ptr[4:0];
	assign mif.wdata = next_sh;
	assign mif.raddr = ptr[4:0];
	assign mif.hold = clock_hold;

	always_ff @(posedge clk) begin
		if (sys_rst || ce_s) begin
			active <= 1'b0;
		end else if (ce_fall) begin
			// nothing happens until a chip enable fall is seen [RULE5]
			active <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || ce_fall) begin
			state <= RSP_CMD;
			cnt <= 3'h0;
		end else if (rise) begin
			// every bit counts, bursts run while selected [RULE12]
			cnt <= cnt + 3'h1;
			if (cmd_end) begin
				// first bit chooses write or read [RULE11]
				state <= (next_sh[`RSP_DIR_BIT] == `RSP_DIR_WRITE) ?
					RSP_WR : RSP_RD;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || ce_fall) begin
			sh <= `RSP_BYTE_RESET;
		end else if (rise) begin
			sh <= next_sh; // [RULE1]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ptr <= `RSP_PTR_RESET;
		end else if (cmd_end) begin
			// six of the seven address bits kept, msb first [RULE11]
			ptr <= next_sh[5:0];
		end else if (data_end) begin
			// six-bit pointer rolls from 3Fh to 00h [RULE6] [RULE12]
			ptr <= ptr + 6'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx <= `RSP_BYTE_RESET;
			serial_out <= 1'b0;
		end else if (fall && (state == RSP_RD)) begin
			// reload at each byte start from the current pointer [RULE16]
			serial_out <= rd_byte[7]; // [RULE2]
			tx <= {rd_byte[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !live || state != RSP_RD) begin
			// deselected or writing: the pin stays released [RULE4] [RULE9]
			serial_out_oe <= 1'b0;
		end else if (rd_load) begin
			// drive only once a whole byte is ready [RULE7]
			serial_out_oe <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clock_hold <= 1'b0;
		end else begin
			clock_hold <= next_hold; // [RULE14]
		end
	end

	// checks
	a_sample_rise: assert property ( // [RULE1]
		@(posedge clk) disable iff (sys_rst)
		rise |=> sh[0] == $past(sin_s))
		else $error("input bit not taken on rise");

	a_out_on_fall: assert property ( // [RULE2]
		@(posedge clk) disable iff (sys_rst)
		$changed(serial_out) |-> $past(fall))
		else $error("output changed without sclk fall");

	a_deselect_hiz: assert property ( // [RULE4]
		@(posedge clk) disable iff (sys_rst)
		ce_s |=> !serial_out_oe)
		else $error("output driven while deselected");

	a_ignore_idle: assert property ( // [RULE5] [RULE8]
		@(posedge clk) disable iff (sys_rst)
		!active && !ce_fall |=> $stable(ptr) && $stable(cnt) && $stable(sh))
		else $error("state moved while not selected");

	a_ptr_advance: assert property ( // [RULE6] [RULE12]
		@(posedge clk) disable iff (sys_rst)
		data_end |=> ptr == 6'($past(ptr) + 6'h1))
		else $error("pointer did not advance by one");

	a_cmd_undriven: assert property ( // [RULE7]
		@(posedge clk) disable iff (sys_rst)
		state == RSP_CMD |-> !serial_out_oe)
		else $error("output driven before a byte is ready");

	a_write_undriven: assert property ( // [RULE9]
		@(posedge clk) disable iff (sys_rst)
		state == RSP_WR |-> !serial_out_oe)
		else $error("output driven during write");

	a_cmd_decode: assert property ( // [RULE11] [RULE13]
		@(posedge clk) disable iff (sys_rst)
		cmd_end |=> ptr == $past(next_sh[5:0]) &&
		(state == RSP_WR) == $past(next_sh[7]))
		else $error("command byte decoded wrongly");

	a_hold_clock: assert property ( // [RULE14]
		@(posedge clk) disable iff (sys_rst)
		next_hold |=> clock_hold)
		else $error("clock hold not raised");

	// updates must resume as soon as the host lets go
	a_hold_release: assert property ( // [RULE14]
		@(posedge clk) disable iff (sys_rst)
		!live |=> !clock_hold)
		else $error("clock hold kept while deselected");

	a_no_partial: assert property ( // [RULE15]
		@(posedge clk) disable iff (sys_rst)
		mif.we |-> live && cnt == `RSP_LAST_BIT && state == RSP_WR)
		else $error("write from a partial byte");

	a_fresh_cmd: assert property ( // [RULE15]
		@(posedge clk) disable iff (sys_rst)
		ce_fall |=> state == RSP_CMD && cnt == 3'h0 && !serial_out_oe)
		else $error("transfer did not restart with a command byte");

	a_read_msb: assert property ( // [RULE16]
		@(posedge clk) disable iff (sys_rst)
		rd_load |=> serial_out == $past(mif.rdata[7]) && serial_out_oe)
		else $error("read byte not started msb first");
endmodule
`default_nettype wire

// ### rsp_regs.svh
/*
 * constants of the serial access port: map size, field positions,
 * reset values and the byte layout of the command.
 * assumes it is included by the port and its byte map.
 */
// Operation
// RULE1: sample serial_in on every sclk rising edge
// RULE2: change serial_out after each sclk falling edge
// RULE3: mode 0 only, sclk idles low
// RULE4: deselected means serial_out held high impedance
// RULE5: start only after a chip enable fall
// RULE6: pointer increments after every data byte
// RULE7: read output undriven until whole byte ready
// RULE8: deselected ignores sclk and serial_in entirely
// RULE9: write keeps serial_out undriven throughout
// RULE10: map: 8 clock, 17 control, 7 sram
// RULE11: first bit direction, next seven address
// RULE12: burst while selected, pointer wraps 3Fh to 00h
// RULE13: address bit 6 ignored when decoding
// RULE14: hold clock updates while pointer at 00h-07h
// RULE15: partial byte on deselect is discarded
// RULE16: read msb first, reload from incremented pointer
`ifndef RSP_REGS_SVH
`define RSP_REGS_SVH

`define RSP_MAP_BYTES 32
`define RSP_CLOCK_BYTES 8
`define RSP_CTRL_BYTES 17
`define RSP_SRAM_BYTES 7
`define RSP_DIR_BIT 7
`define RSP_DIR_WRITE 1'b1
`define RSP_PTR_WRAP 6'h3f
`define RSP_PTR_RESET 6'h00
`define RSP_LAST_BIT 3'h7
`define RSP_BYTE_RESET 8'h00

`endif

// ### rsp_pkg.sv
/*
 * types of the serial access port.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package rsp_pkg;

	typedef enum logic [2:0] {
		RSP_CMD = 3'b001,
		RSP_WR  = 3'b010,
		RSP_RD  = 3'b100
	} rsp_state_t;

	typedef logic [5:0] rsp_ptr_t;
	typedef logic [4:0] rsp_loc_t;

	// clock bytes sit at locations 00h-07h, bit 5 aliases the map
	function automatic logic rsp_is_clock(input rsp_ptr_t p);
		return p[4:3] == 2'b00;
	endfunction

endpackage
`default_nettype wire

// ### rsp_mem_if.sv
/*
 * carrier between the serial port and its byte map.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface rsp_mem_if;
	import rsp_pkg::*;
	logic we;
	rsp_loc_t waddr;
	logic [7:0] wdata;
	rsp_loc_t raddr;
	logic [7:0] rdata;
	logic hold;

	modport port (output we, output waddr, output wdata, output raddr,
		output hold, input rdata);
	modport map (input we, input waddr, input wdata, input raddr,
		input hold, output rdata);
endinterface
`default_nettype wire

// ### rsp_mem.sv
/*
 * 32-byte map: clock bytes, control bytes and user sram.
 * assumes the timekeeping side offers clock bytes on tk_*.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsp_regs.svh"
module rsp_mem (
	// clock
	input wire logic clk,
	// port side
	rsp_mem_if.map bus,
	// timekeeping side
	input wire logic tk_we,
	input wire logic [2:0] tk_addr,
	input wire logic [7:0] tk_data
);
	import rsp_pkg::*;

	// clock bytes, control bytes, then sram, all one array [RULE10]
	logic [7:0] arr [0:`RSP_MAP_BYTES-1];
	wire tk_go = tk_we && !bus.hold && !bus.we;

	assign bus.rdata = arr[bus.raddr];

	always_ff @(posedge clk) begin
		if (bus.we) begin
			arr[bus.waddr] <= bus.wdata;
		end else if (tk_go) begin
			// time transfers are dropped while the host sits on clock bytes [RULE14]
			arr[{2'b00, tk_addr}] <= tk_data;
		end
	end

	a_tk_blocked: assert property ( // [RULE14]
		@(posedge clk)
		bus.hold && tk_we && !bus.we |=>
		arr[$past({2'b00, tk_addr})] == $past(arr[{2'b00, tk_addr}]))
		else $error("clock byte updated during hold");
endmodule
`default_nettype wire

// ### rsp_master_model.sv
/*
 * mode 0 spi master standing in front of the serial access port.
 * assumes the bench ties miso to serial_out gated by its enable.
 */
`timescale 1ns/1ps
`default_nettype none
module rsp_master_model (
	// serial pins
	output logic sclk,
	output logic ce_n,
	output logic mosi,
	input wire logic miso
);
	// ce_n starts low: a select without a fall must be ignored
	initial begin
		sclk = 1'b0;
		ce_n = 1'b0;
		mosi = 1'b0;
	end

	task automatic sel(input logic on);
		#100 ce_n = !on;
		if (!on)
			mosi = ~mosi;
		#100;
	endtask

	// sampled late in the high phase: the port answers some clk late
	task automatic shift(input int n, input logic [7:0] tx,
		output logic [7:0] rx);
		for (int i = n - 1; i >= 0; i--) begin
			mosi = tx[i];
			#100 sclk = 1'b1;
			#90 rx[i] = miso;
			#10 sclk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ### rsp_spi_tb_top.sv
/*
 * self-checking bench of the serial access port.
 * assumes the master model in rsp_master_model.sv.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module rsp_spi_tb_top;
	logic clk, sys_rst, sclk, ce_n, mosi, serial_out, serial_out_oe;
	logic tk_we, clock_hold, quiet;
	logic [2:0] tk_addr;
	logic [7:0] tk_data, rx;
	logic [7:0] img [32];
	int fails, checks, quiet_bad;
	wire miso = serial_out_oe ? serial_out : 1'bz;

	rsp_master_model m (.sclk(sclk), .ce_n(ce_n), .mosi(mosi),
		.miso(miso));
	rsp_spi dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .ce_n(ce_n),
		.serial_in(mosi), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .tk_we(tk_we), .tk_addr(tk_addr),
		.tk_data(tk_data), .clock_hold(clock_hold));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk)
		if (quiet && serial_out_oe)
			quiet_bad++;

	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmd(input logic [7:0] c);
		quiet = 1'b1;
		m.sel(1'b1);
		m.shift(8, c, rx);
		quiet = c[7];
	endtask

	task automatic done();
		m.sel(1'b0);
		quiet = 1'b0;
		repeat (6) @(posedge clk);
		#2;
		`CHK("oe_idle", 1'b0, serial_out_oe)
	endtask

	task automatic rd(input int a);
		m.shift(8, 8'h00, rx);
		`CHK("rd_byte", img[a], rx)
	endtask

	task automatic tk_pulse(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		#2 tk_we = 1'b1;
		tk_addr = a;
		tk_data = d;
		@(posedge clk);
		#2 tk_we = 1'b0;
	endtask

	// selected through reset and clocked, then clocked again while deselected
	task automatic t_ignore();
		quiet = 1'b1;
		m.shift(8, 8'h00, rx);
		m.shift(8, 8'h00, rx);
		m.sel(1'b0);
		m.shift(8, 8'h00, rx);
		`CHK("ignored", 0, quiet_bad)
		quiet = 1'b0;
	endtask

	// 32 bytes from 3fh: crosses the wrap and covers the whole map
	task automatic t_write();
		cmd(8'hbf);
		for (int i = 0; i < 32; i++) begin
			img[(31 + i) % 32] = 8'(i * 7 + 3);
			m.shift(8, 8'(i * 7 + 3), rx);
		end
		done();
	endtask

	task automatic t_read();
		cmd(8'h40);
		for (int i = 0; i < 32; i++)
			rd(i);
		done();
	endtask

	task automatic t_partial();
		cmd(8'h85);
		m.shift(5, 8'h1f, rx);
		done();
		cmd(8'h05);
		rd(5);
		done();
	endtask

	task automatic t_hold();
		cmd(8'h02);
		rd(2);
		rd(3);
		`CHK("hold", 1'b1, clock_hold)
		tk_pulse(3'h4, 8'h5a);
		for (int i = 4; i < 8; i++)
			rd(i);
		repeat (6) @(posedge clk);
		#2;
		`CHK("hold_off", 1'b0, clock_hold)
		done();
		cmd(8'h04);
		rd(4);
		done();
		tk_pulse(3'h4, 8'ha5);
		img[4] = 8'ha5;
		cmd(8'h04);
		rd(4);
		done();
	endtask

	initial begin
		#1_000_000;
		fails++;
		tally_and_finish();
	end

	initial begin
		sys_rst = 1'b1;
		tk_we = 1'b0;
		tk_addr = 3'h0;
		tk_data = 8'h00;
		quiet = 1'b0;
		repeat (10) @(posedge clk);
		#2 sys_rst = 1'b0;
		t_ignore();
		t_write();
		t_read();
		t_partial();
		t_hold();
		`CHK("quiet_oe", 0, quiet_bad)
		tally_and_finish();
	end
endmodule
`default_nettype wire
